/* rtl/aaad_alu.v */
`timescale 1ns/1ps
module aaad_alu (
    input  wire [15:0] a_i,
    input  wire [15:0] b_i,
    input  wire        cin_i,
    input  wire        wide_i,
    output wire [15:0] res_o,
    output wire        of_o,
    output wire        sf_o,
    output wire        zf_o,
    output wire        af_o,
    output wire        pf_o,
    output wire        cf_o
);
    wire [8:0]  sum_b;
    wire [16:0] sum_w;
    wire        msb_a;
    wire        msb_b;

    assign sum_b = {1'b0, a_i[7:0]} + {1'b0, b_i[7:0]} + {8'h00, cin_i};
    assign sum_w = {1'b0, a_i} + {1'b0, b_i} + {16'h0000, cin_i};
    assign res_o = wide_i ? sum_w[15:0] : {8'h00, sum_b[7:0]};
    assign cf_o  = wide_i ? sum_w[16] : sum_b[8];
    assign msb_a = wide_i ? a_i[15] : a_i[7];
    assign msb_b = wide_i ? b_i[15] : b_i[7];
    assign sf_o  = wide_i ? res_o[15] : res_o[7];
    // Signed overflow: like signs in, other sign out
    assign of_o  = (msb_a == msb_b) & (sf_o != msb_a);
    assign zf_o  = wide_i ? (res_o == 16'h0000) : (res_o[7:0] == 8'h00);
    assign af_o  = a_i[4] ^ b_i[4] ^ res_o[4];
    assign pf_o  = ~^res_o[7:0];
endmodule // aaad_alu

/* rtl/aaad_bcd.v */
`timescale 1ns/1ps
module aaad_bcd (
    input  wire [1:0]  sel_i,
    input  wire [15:0] acc_i,
    input  wire [7:0]  base_i,
    input  wire        af_i,
    output reg  [15:0] acc_o,
    output reg         adj_o,
    output wire        div_zero_o
);
    wire        need_adj;
    wire [7:0]  lo_add;
    wire [7:0]  lo_sub;
    wire [15:0] prod;
    wire [7:0]  base_safe;
    wire [7:0]  quot;
    wire [7:0]  rem;
    wire [7:0]  aad_lo;

    assign need_adj   = (acc_i[3:0] > 4'h9) | af_i;
    assign lo_add     = acc_i[7:0] + 8'h06;
    assign lo_sub     = acc_i[7:0] - 8'h06;
    assign prod       = acc_i[15:8] * base_i;
    assign aad_lo     = acc_i[7:0] + prod[7:0];
    // Zero radix would divide by zero; the core refuses it
    assign div_zero_o = (base_i == 8'h00);
    assign base_safe  = div_zero_o ? 8'h01 : base_i;
    assign quot       = acc_i[7:0] / base_safe;
    assign rem        = acc_i[7:0] % base_safe;

    always @* begin
        adj_o = 1'b0;
        acc_o = acc_i;
        case (sel_i)
            2'd0: begin
                adj_o = need_adj;
                acc_o = need_adj ? {acc_i[15:8] + 8'h01, 4'h0, lo_add[3:0]}
                                 : {acc_i[15:8], 4'h0, acc_i[3:0]};
            end
            2'd1: begin
                adj_o = need_adj;
                acc_o = need_adj ? {acc_i[15:8] - 8'h01, 4'h0, lo_sub[3:0]}
                                 : {acc_i[15:8], 4'h0, acc_i[3:0]};
            end
            2'd2: acc_o = {8'h00, aad_lo};
            2'd3: acc_o = {quot, rem};
            default: acc_o = acc_i;
        endcase
    end
endmodule // aaad_bcd

/* rtl/aaad_core.v */
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
`include "aaad_defs.vh"
module aaad_core (
    input  wire        mclk_i,
    input  wire        sys_rst_i,
    input  wire        fb_valid_i,
    input  wire [7:0]  fb_byte_i,
    output wire        fb_ready_o,
    input  wire [15:0] opnd_rm_i,
    input  wire [15:0] opnd_reg_i,
    output wire        done_o,
    output wire [15:0] result_o,
    output wire        result_mem_o,
    output wire        result_wide_o,
    output wire        result_to_reg_o,
    output wire [7:0]  modrm_o,
    output wire [4:0]  cycles_o,
    input  wire [3:0]  reg_addr_i,
    input  wire [15:0] reg_wdata_i,
    input  wire        reg_we_i,
    input  wire        reg_re_i,
    output wire [15:0] reg_rdata_o
);
    localparam [2:0] S_OP     = 3'd0;
    localparam [2:0] S_SECOND = 3'd1;
    localparam [2:0] S_MODRM  = 3'd2;
    localparam [2:0] S_IML    = 3'd3;
    localparam [2:0] S_IMH    = 3'd4;
    localparam [2:0] S_EXEC   = 3'd5;

    localparam [2:0] CL_BAD   = 3'd0;
    localparam [2:0] CL_ADJ1  = 3'd1;
    localparam [2:0] CL_ADJ2  = 3'd2;
    localparam [2:0] CL_ACC   = 3'd3;
    localparam [2:0] CL_RM    = 3'd4;
    localparam [2:0] CL_GRP   = 3'd5;

    reg  [2:0]  state_r, state_nxt;
    reg  [7:0]  op_r, modrm_r, base_r;
    reg  [15:0] imm_r, acc_r, flags_r, result_r, rdata_r;
    reg  [4:0]  cnt_r, cycles_r;
    reg         narrow_r, illegal_r, done_r, ready_r;
    reg         mem_r, wide_r, to_reg_r;
    reg         last_byte, bad_byte, alu_wide, use_carry;
    reg  [15:0] flags_new, flags_mask, alu_a, alu_b;

    wire        take, mem_now, fire, is_adj, adj_refused;
    wire [7:0]  op_now;
    wire [2:0]  cls_now;
    wire [15:0] alu_res, bcd_acc;
    wire        alu_of, alu_sf, alu_zf, alu_af, alu_pf, alu_cf;
    wire        bcd_adj, bcd_dz;
    wire [1:0]  bcd_sel;

    function [2:0] cls_of;
        input [7:0] op;
        begin
            case (op)
                `AAAD_OP_ADJ_ADD, `AAAD_OP_ADJ_SUB: cls_of = CL_ADJ1;
                `AAAD_OP_ADJ_DIV, `AAAD_OP_ADJ_MUL: cls_of = CL_ADJ2;
                `AAAD_OP_ADD_ACCB, `AAAD_OP_ADD_ACCW,
                `AAAD_OP_ADC_ACCB, `AAAD_OP_ADC_ACCW: cls_of = CL_ACC;
                8'h00, 8'h01, 8'h02, 8'h03,
                8'h10, 8'h11, 8'h12, 8'h13: cls_of = CL_RM;
                `AAAD_OP_GRP_B, `AAAD_OP_GRP_W, `AAAD_OP_GRP_SX: cls_of = CL_GRP;
                default: cls_of = CL_BAD;
            endcase
        end
    endfunction

    // Clock count per form; narrow selects the 8-bit bus variant
    function [4:0] cyc_of;
        input [7:0] op;
        input       mem;
        input       narrow;
        begin
            case (op)
                `AAAD_OP_ADJ_ADD: cyc_of = `AAAD_CYC_ADJ_ADD;
                `AAAD_OP_ADJ_DIV: cyc_of = `AAAD_CYC_ADJ_DIV;
                `AAAD_OP_ADJ_MUL: cyc_of = `AAAD_CYC_ADJ_MUL;
                `AAAD_OP_ADJ_SUB: cyc_of = `AAAD_CYC_ADJ_SUB;
                `AAAD_OP_ADD_ACCB, `AAAD_OP_ADC_ACCB: cyc_of = `AAAD_CYC_ACC_B;
                `AAAD_OP_ADD_ACCW, `AAAD_OP_ADC_ACCW: cyc_of = `AAAD_CYC_ACC_W;
                `AAAD_OP_GRP_B: cyc_of = mem ? `AAAD_CYC_IM_MEM : `AAAD_CYC_IM_REG;
                `AAAD_OP_GRP_W, `AAAD_OP_GRP_SX:
                    cyc_of = !mem ? `AAAD_CYC_IM_REG
                           : (narrow ? `AAAD_CYC_IM_MEM_N : `AAAD_CYC_IM_MEM);
                8'h00, 8'h02, 8'h10, 8'h12:
                    cyc_of = mem ? `AAAD_CYC_RM_MEM : `AAAD_CYC_RM_REG;
                8'h01, 8'h03, 8'h11, 8'h13:
                    cyc_of = !mem ? `AAAD_CYC_RM_REG
                           : (narrow ? `AAAD_CYC_RM_MEM_N : `AAAD_CYC_RM_MEM);
                default: cyc_of = `AAAD_CYC_RM_REG;
            endcase
        end
    endfunction

    assign take    = fb_valid_i & ready_r;
    assign op_now  = (state_r == S_OP) ? fb_byte_i : op_r;
    assign cls_now = cls_of(op_now);
    assign mem_now = (state_r == S_MODRM) ? (fb_byte_i[7:6] != 2'b11) : (modrm_r[7:6] != 2'b11);
    assign fire    = (state_r == S_EXEC) & (cnt_r == 5'd1);
    assign is_adj  = (cls_of(op_r) == CL_ADJ1) | (cls_of(op_r) == CL_ADJ2);
    assign bcd_sel = (op_r == `AAAD_OP_ADJ_ADD) ? 2'd0 :
                     (op_r == `AAAD_OP_ADJ_SUB) ? 2'd1 :
                     (op_r == `AAAD_OP_ADJ_DIV) ? 2'd2 : 2'd3;
    // A zero radix on the multiply adjust is refused: acc and flags hold, illegal is set
    assign adj_refused = is_adj & (bcd_sel == 2'd3) & bcd_dz;

    always @* begin
        state_nxt = state_r;
        last_byte = 1'b0;
        bad_byte  = 1'b0;
        case (state_r)
            S_OP: begin
                if (take) begin
                    case (cls_now)
                        CL_ADJ1: begin
                            state_nxt = S_EXEC;
                            last_byte = 1'b1;
                        end
                        CL_ADJ2: state_nxt = S_SECOND;
                        CL_ACC:  state_nxt = S_IML;
                        CL_RM:   state_nxt = S_MODRM;
                        CL_GRP:  state_nxt = S_MODRM;
                        default: bad_byte = 1'b1;
                    endcase
                end
            end
            S_SECOND, S_IMH: begin
                if (take) begin
                    state_nxt = S_EXEC;
                    last_byte = 1'b1;
                end
            end
            S_MODRM: begin
                if (take) begin
                    if (cls_now == CL_RM) begin
                        state_nxt = S_EXEC;
                        last_byte = 1'b1;
                    end else if (fb_byte_i[5:3] == `AAAD_GRP_ADD || fb_byte_i[5:3] == `AAAD_GRP_ADC) begin
                        state_nxt = S_IML;
                    end else begin
                        state_nxt = S_OP;
                        bad_byte  = 1'b1;
                    end
                end
            end
            S_IML: begin
                if (take) begin
                    if (op_r == `AAAD_OP_ADC_ACCW || op_r == `AAAD_OP_ADD_ACCW || op_r == `AAAD_OP_GRP_W) begin
                        state_nxt = S_IMH;
                    end else begin
                        state_nxt = S_EXEC;
                        last_byte = 1'b1;
                    end
                end
            end
            S_EXEC: begin
                state_nxt = fire ? S_OP : S_EXEC;
            end
            default: state_nxt = S_OP;
        endcase
    end

    // Operand steering into the shared adder
    always @* begin
        alu_a     = opnd_rm_i;
        alu_b     = opnd_reg_i;
        alu_wide  = op_r[0];
        use_carry = op_r[4];
        case (cls_of(op_r))
            CL_ACC: begin
                alu_a = acc_r;
                alu_b = imm_r;
            end
            CL_GRP: begin
                alu_b     = (op_r == `AAAD_OP_GRP_SX) ? {{8{imm_r[7]}}, imm_r[7:0]} : imm_r;
                alu_wide  = (op_r != `AAAD_OP_GRP_B);
                use_carry = (modrm_r[5:3] == `AAAD_GRP_ADC);
            end
            default: alu_a = opnd_rm_i;
        endcase
    end

    aaad_alu aaad_alu_inst (
        .a_i    (alu_a),
        .b_i    (alu_b),
        .cin_i  (use_carry & flags_r[`AAAD_FLAG_C]),
        .wide_i (alu_wide),
        .res_o  (alu_res),
        .of_o   (alu_of),
        .sf_o   (alu_sf),
        .zf_o   (alu_zf),
        .af_o   (alu_af),
        .pf_o   (alu_pf),
        .cf_o   (alu_cf)
    );

    aaad_bcd aaad_bcd_inst (
        .sel_i      (bcd_sel),
        .acc_i      (acc_r),
        .base_i     (base_r),
        .af_i       (flags_r[`AAAD_FLAG_A]),
        .acc_o      (bcd_acc),
        .adj_o      (bcd_adj),
        .div_zero_o (bcd_dz)
    );

    // Undefined flags are left as they were
    always @* begin
        flags_new  = 16'h0000;
        flags_mask = 16'h0000;
        if (is_adj) begin
            if (bcd_sel[1]) begin
                flags_new[`AAAD_FLAG_S] = bcd_acc[7];
                flags_new[`AAAD_FLAG_Z] = (bcd_acc[7:0] == 8'h00);
                flags_new[`AAAD_FLAG_P] = ~^bcd_acc[7:0];
                flags_mask = adj_refused ? 16'h0000 : `AAAD_MASK_SZP;
            end else begin
                flags_new[`AAAD_FLAG_A] = bcd_adj;
                flags_new[`AAAD_FLAG_C] = bcd_adj;
                flags_mask = `AAAD_MASK_AC;
            end
        end else begin
            flags_new[`AAAD_FLAG_O] = alu_of;
            flags_new[`AAAD_FLAG_S] = alu_sf;
            flags_new[`AAAD_FLAG_Z] = alu_zf;
            flags_new[`AAAD_FLAG_A] = alu_af;
            flags_new[`AAAD_FLAG_P] = alu_pf;
            flags_new[`AAAD_FLAG_C] = alu_cf;
            flags_mask = `AAAD_MASK_ARITH;
        end
    end

    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_r   <= S_OP;
            op_r      <= 8'h00;
            modrm_r   <= 8'h00;
            imm_r     <= 16'h0000;
            base_r    <= 8'h00;
            cnt_r     <= 5'd0;
            ready_r   <= 1'b0;
            done_r    <= 1'b0;
            result_r  <= 16'h0000;
            mem_r     <= 1'b0;
            wide_r    <= 1'b0;
            to_reg_r  <= 1'b0;
            cycles_r  <= 5'd0;
        end else begin
            state_r <= state_nxt;
            ready_r <= (state_nxt != S_EXEC);
            done_r  <= fire;
            if (take && state_r == S_OP) begin
                op_r    <= fb_byte_i;
                modrm_r <= 8'hC0;
                imm_r   <= 16'h0000;
            end
            if (take && state_r == S_SECOND) base_r <= fb_byte_i;
            if (take && state_r == S_MODRM) modrm_r <= fb_byte_i;
            if (take && state_r == S_IML) imm_r[7:0] <= fb_byte_i;
            if (take && state_r == S_IMH) imm_r[15:8] <= fb_byte_i;
            if (last_byte) begin
                cnt_r    <= cyc_of(op_now, mem_now & ((cls_now == CL_RM) | (cls_now == CL_GRP)), narrow_r);
                cycles_r <= cyc_of(op_now, mem_now & ((cls_now == CL_RM) | (cls_now == CL_GRP)), narrow_r);
            end else if (state_r == S_EXEC) begin
                cnt_r <= cnt_r - 5'd1;
            end
            if (fire) begin
                result_r <= is_adj ? (adj_refused ? acc_r : bcd_acc) : alu_res;
                mem_r    <= (cls_of(op_r) != CL_ACC) & !is_adj & (modrm_r[7:6] != 2'b11);
                wide_r   <= is_adj ? 1'b1 : alu_wide;
                to_reg_r <= (cls_of(op_r) == CL_RM) & op_r[1];
            end
        end
    end

    // Software writes first, the instruction's own update overrides
    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            acc_r     <= `AAAD_ACC_RST;
            flags_r   <= `AAAD_FLAGS_RST;
            narrow_r  <= `AAAD_CTRL_RST;
            illegal_r <= 1'b0;
            rdata_r   <= 16'h0000;
        end else begin
            if (reg_we_i) begin
                case (reg_addr_i)
                    `AAAD_REG_CTRL:   narrow_r <= reg_wdata_i[0];
                    `AAAD_REG_ACC:    acc_r <= reg_wdata_i;
                    `AAAD_REG_FLAGS:  flags_r <= reg_wdata_i;
                    `AAAD_REG_STATUS: if (reg_wdata_i[1]) illegal_r <= 1'b0;
                    default: narrow_r <= narrow_r;
                endcase
            end
            // Set wins over a same-cycle clear
            if (bad_byte || (fire && adj_refused)) begin
                illegal_r <= 1'b1;
            end
            if (fire) begin
                flags_r <= (flags_r & ~flags_mask) | (flags_new & flags_mask);
                if (is_adj && !adj_refused) begin
                    acc_r <= bcd_acc;
                end else if (cls_of(op_r) == CL_ACC) begin
                    acc_r <= alu_wide ? alu_res : {acc_r[15:8], alu_res[7:0]};
                end
            end
            rdata_r <= 16'h0000;
            if (reg_re_i) begin
                case (reg_addr_i)
                    `AAAD_REG_CTRL:   rdata_r <= {15'h0000, narrow_r};
                    `AAAD_REG_ACC:    rdata_r <= acc_r;
                    `AAAD_REG_FLAGS:  rdata_r <= flags_r;
                    `AAAD_REG_STATUS: rdata_r <= {op_r, 5'h00, mem_r, illegal_r, (state_r != S_OP)};
                    `AAAD_REG_RESULT: rdata_r <= result_r;
                    `AAAD_REG_CYCLES: rdata_r <= {11'h000, cycles_r};
                    default:          rdata_r <= 16'h0000;
                endcase
            end
        end
    end

    assign fb_ready_o      = ready_r;
    assign done_o          = done_r;
    assign result_o        = result_r;
    assign result_mem_o    = mem_r;
    assign result_wide_o   = wide_r;
    assign result_to_reg_o = to_reg_r;
    assign modrm_o         = modrm_r;
    assign cycles_o        = cycles_r;
    assign reg_rdata_o     = rdata_r;
endmodule // aaad_core

/* rtl/aaad_defs.vh */
`ifndef AAAD_DEFS_VH
`define AAAD_DEFS_VH

`define AAAD_REG_CTRL      4'h0
`define AAAD_REG_ACC       4'h1
`define AAAD_REG_FLAGS     4'h2
`define AAAD_REG_STATUS    4'h3
`define AAAD_REG_RESULT    4'h4
`define AAAD_REG_CYCLES    4'h5

`define AAAD_CTRL_RST      1'b0
`define AAAD_ACC_RST       16'h0000
`define AAAD_FLAGS_RST     16'h0000

`define AAAD_FLAG_C        0
`define AAAD_FLAG_P        2
`define AAAD_FLAG_A        4
`define AAAD_FLAG_Z        6
`define AAAD_FLAG_S        7
`define AAAD_FLAG_O        11
`define AAAD_MASK_ARITH    16'h08D5
`define AAAD_MASK_AC       16'h0011
`define AAAD_MASK_SZP      16'h00C4

`define AAAD_OP_ADJ_ADD    8'h37
`define AAAD_OP_ADJ_SUB    8'h3F
`define AAAD_OP_ADJ_DIV    8'hD5
`define AAAD_OP_ADJ_MUL    8'hD4
`define AAAD_OP_ADD_ACCB   8'h04
`define AAAD_OP_ADD_ACCW   8'h05
`define AAAD_OP_ADC_ACCB   8'h14
`define AAAD_OP_ADC_ACCW   8'h15
`define AAAD_OP_GRP_B      8'h80
`define AAAD_OP_GRP_W      8'h81
`define AAAD_OP_GRP_SX     8'h83
`define AAAD_GRP_ADD       3'h0
`define AAAD_GRP_ADC       3'h2

`define AAAD_CYC_ADJ_ADD   5'd8
`define AAAD_CYC_ADJ_DIV   5'd15
`define AAAD_CYC_ADJ_MUL   5'd19
`define AAAD_CYC_ADJ_SUB   5'd7
`define AAAD_CYC_ACC_B     5'd3
`define AAAD_CYC_ACC_W     5'd4
`define AAAD_CYC_RM_REG    5'd3
`define AAAD_CYC_RM_MEM    5'd10
`define AAAD_CYC_RM_MEM_N  5'd14
`define AAAD_CYC_IM_REG    5'd4
`define AAAD_CYC_IM_MEM    5'd16
`define AAAD_CYC_IM_MEM_N  5'd20

`endif

/* tb/aaad_core_bench.sv */
`timescale 1ns/1ps
module aaad_core_bench;
    logic        mclk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        fb_valid_i, fb_ready_o, done_o, result_mem_o, result_wide_o, result_to_reg_o, slow = 1'b0;
    logic        reg_we_i = 1'b0, reg_re_i = 1'b0;
    logic [7:0]  fb_byte_i, modrm_o;
    logic [4:0]  cycles_o;
    logic [3:0]  reg_addr_i = 4'h0;
    logic [15:0] opnd_rm_i = 16'h0000, opnd_reg_i = 16'h0001, reg_wdata_i = 16'h0000, result_o, reg_rdata_o;
    int          mismatches = 0, checks_done = 0, ticks = 0;
    logic [7:0]  ops [14] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h10, 8'h11, 8'h12, 8'h13,
                              8'h80, 8'h81, 8'h83, 8'h80, 8'h81, 8'h83};
    initial begin
        forever #12.5 mclk_i = ~mclk_i;
    end
    aaad_core aaad_core_inst (.mclk_i, .sys_rst_i, .fb_valid_i, .fb_byte_i, .fb_ready_o, .opnd_rm_i,
        .opnd_reg_i, .done_o, .result_o, .result_mem_o, .result_wide_o, .result_to_reg_o, .modrm_o,
        .cycles_o, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o);
    aaad_fetch_model aaad_fetch_model_inst (.mclk_i, .sys_rst_i, .fb_ready_o, .slow_i(slow), .fb_valid_i,
        .fb_byte_i);
    task end_of_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge mclk_i);
        reg_we_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= v;
        @(posedge mclk_i);
        reg_we_i <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge mclk_i);
        reg_re_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge mclk_i);
        reg_re_i <= 1'b0;
        #1 check(reg_rdata_o, exp);
    endtask
    task send(input logic [7:0] b [$]);
        foreach (b[i]) aaad_fetch_model_inst.push(b[i]);
    endtask
    // Bounded wait so a lost done shows as a mismatch, not a hang
    task wait_done(input logic [4:0] cyc);
        int n;
        n = 0;
        do begin
            @(posedge mclk_i);
            #1 n++;
        end while (done_o !== 1'b1 && n < 60);
        check({15'h0, done_o}, 16'h0001);
        check({11'h0, cycles_o}, {11'h0, cyc});
    endtask
    task t_acc;
        wr(4'h1, 16'h12F0);
        wr(4'h2, 16'h0200);
        send('{8'h04, 8'h20, 8'h14, 8'h05});
        wait_done(5'h03);
        wait_done(5'h03);
        rd(4'h1, 16'h1216);
        rd(4'h2, 16'h0200);
        send('{8'h15, 8'h00, 8'h01});
        wait_done(5'h04);
        send('{8'h05, 8'hFF, 8'hFF});
        wait_done(5'h04);
        rd(4'h1, 16'h1315);
        rd(4'h2, 16'h0211);
        $display("accumulator forms finished");
    endtask
    task t_adj;
        wr(4'h1, 16'h000B);
        wr(4'h2, 16'h0000);
        send('{8'h37});
        wait_done(5'h08);
        rd(4'h1, 16'h0101);
        rd(4'h2, 16'h0011);
        wr(4'h1, 16'h020C);
        send('{8'h3F});
        wait_done(5'h07);
        rd(4'h1, 16'h0106);
        wr(4'h1, 16'h0307);
        send('{8'hD5, 8'h0A});
        wait_done(5'h0F);
        rd(4'h1, 16'h0025);
        send('{8'hD4, 8'h0A});
        wait_done(5'h13);
        rd(4'h1, 16'h0307);
        rd(4'h2, 16'h0011);
        send('{8'hD4, 8'h00});
        wait_done(5'h13);
        rd(4'h1, 16'h0307);
        rd(4'h3, 16'hD402);
        wr(4'h3, 16'h0002);
        rd(4'h3, 16'hD400);
        wr(4'hF, 16'h1234);
        rd(4'hF, 16'h0000);
        // Undefined opcode, then a group form with reg field 1: both refused
        send('{8'hF4, 8'h80, 8'h08});
        repeat (8) @(posedge mclk_i);
        rd(4'h3, 16'h8002);
        $display("adjust forms finished");
    endtask
    task t_rm;
        logic [7:0]  op;
        logic [2:0]  r;
        logic        c;
        logic [4:0]  cy;
        logic [15:0] e;
        for (int i = 0; i < 14; i++) for (int k = 0; k < 3; k++) begin
            op = ops[i];
            r = (i > 10) ? 3'h2 : 3'h0;
            c = (i < 8) ? op[4] : r[1];
            wr(4'h0, {15'h0, k == 2});
            wr(4'h2, 16'h0001);
            opnd_rm_i <= (i < 8) ? 16'h01FF : 16'h0100;
            slow <= (k == 1);
            send('{op, {(k == 0) ? 2'b11 : 2'b00, r, (k == 0) ? 3'h0 : 3'h6}});
            if (i >= 8) send('{8'h80});
            if (op == 8'h81) send('{8'hFF});
            e = (i >= 8) ? 16'h0080 + {15'h0, c} : (op[0] ? 16'h0200 + {15'h0, c} : {15'h0, c});
            cy = (i >= 8) ? ((k == 0) ? 5'h04 : (k == 2 && op != 8'h80) ? 5'h14 : 5'h10)
                          : ((k == 0) ? 5'h03 : (k == 2 && op[0]) ? 5'h0E : 5'h0A);
            wait_done(cy);
            check(result_o, e);
            check({15'h0, result_mem_o}, {15'h0, k != 0});
            check({15'h0, result_to_reg_o}, {15'h0, i < 8 && op[1]});
            check({15'h0, result_wide_o}, {15'h0, op[0]});
        end
        $display("operand forms finished");
    endtask
    always @(posedge mclk_i) begin
        ticks++;
        if (ticks == 20000) begin
            mismatches++;
            end_of_test;
        end
    end
    initial begin
        repeat (20) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        t_acc;
        t_adj;
        t_rm;
        end_of_test;
    end
endmodule // aaad_core_bench

/* tb/aaad_core_props.sv */
`timescale 1ns/1ps
module aaad_core_props (
    input wire        mclk_i,
    input wire        sys_rst_i,
    input wire        fb_ready_o,
    input wire        done_o,
    input wire [15:0] result_o,
    input wire        result_mem_o,
    input wire        result_to_reg_o,
    input wire [7:0]  modrm_o,
    input wire [4:0]  cycles_o
);
    reg [4:0] low_cnt_r;
    // Cycles with fetch stalled since the last byte was taken
    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) low_cnt_r <= 5'h00;
        else if (fb_ready_o) low_cnt_r <= 5'h00;
        else low_cnt_r <= low_cnt_r + 5'h01;
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    chk_count_match: assert property (done_o |-> low_cnt_r == cycles_o)
        else $error("done latency differs from clock count");
    chk_count_legal: assert property (done_o |-> cycles_o inside {3, 4, 7, 8, 10, 14, 15, 16, 19, 20})
        else $error("clock count not a listed value");
    chk_done_single: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
    chk_ready_done: assert property (done_o |-> fb_ready_o)
        else $error("fetch not open in done cycle");
    chk_mem_decode: assert property (done_o |-> result_mem_o == (modrm_o[7:6] != 2'b11))
        else $error("memory flag disagrees with mode field");
    chk_reg_count: assert property (done_o && !result_mem_o |-> cycles_o inside {3, 4, 7, 8, 15, 19})
        else $error("register form count wrong");
    chk_mem_count: assert property (done_o && result_mem_o |-> cycles_o inside {10, 14, 16, 20})
        else $error("memory form count wrong");
    chk_to_reg_count: assert property (done_o && result_to_reg_o |-> cycles_o inside {3, 10, 14})
        else $error("reverse form count wrong");
    chk_result_hold: assert property (!done_o |-> $stable(result_o))
        else $error("result moved without done");
endmodule // aaad_core_props
bind aaad_core aaad_core_props aaad_core_props_inst (.mclk_i, .sys_rst_i, .fb_ready_o, .done_o, .result_o,
    .result_mem_o, .result_to_reg_o, .modrm_o, .cycles_o);

/* tb/aaad_fetch_model.sv */
`timescale 1ns/1ps
module aaad_fetch_model (
    input  wire        mclk_i,
    input  wire        sys_rst_i,
    input  wire        fb_ready_o,
    input  wire        slow_i,
    output logic       fb_valid_i = 1'b0,
    output logic [7:0] fb_byte_i = 8'h00
);
    logic [7:0] q [$];
    task push(input logic [7:0] b);
        q.push_back(b);
    endtask
    // Idle byte keeps changing so a stale value never looks fresh
    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fb_valid_i <= 1'b0;
        end else begin
            if (fb_valid_i && fb_ready_o) void'(q.pop_front());
            if (q.size() != 0 && !(slow_i && fb_valid_i && fb_ready_o)) begin
                fb_valid_i <= 1'b1;
                fb_byte_i <= q[0];
            end else begin
                fb_valid_i <= 1'b0;
                fb_byte_i <= ~fb_byte_i;
            end
        end
    end
endmodule // aaad_fetch_model
